// [bpt_map.svh]
// Offsets, field positions, reset values and timing counts of the block
`ifndef BPT_MAP_SVH
`define BPT_MAP_SVH
`define BPT_AW           8
`define BPT_OFF_WREG     8'h00
`define BPT_OFF_TPTR     8'h04
`define BPT_OFF_FLAGS    8'h08
`define BPT_OFF_PTRS     8'h0C
`define BPT_OFF_STAT     8'h10
`define BPT_OFF_TARGET   8'h14
`define BPT_RESP_OK      2'h0
`define BPT_RESP_ERR     2'h2
`define BPT_IX_P0        4'h0
`define BPT_IX_P1        4'h2
`define BPT_IX_P2        4'h4
`define BPT_IX_P3        4'h6
`define BPT_IX_FLAGS     4'hA
`define BPT_IX_WREG      4'hC
`define BPT_CY_POS       3'h7
`define BPT_RS_HI        4
`define BPT_RS_LO        3
`define BPT_RAM_BIT_BASE 8'h20
`define BPT_RESET_BYTE   8'h00
`define BPT_RESET_WORD   16'h0000
`define BPT_STATES_PER_MC 6
`define BPT_OSC_PER_STATE 2
`define BPT_CLK_PER_MC   (`BPT_STATES_PER_MC * `BPT_OSC_PER_STATE)
`define BPT_CNT_W        5
`define BPT_LAST_ONE     5'(`BPT_CLK_PER_MC - 1)
`define BPT_LAST_EXT     5'(2 * `BPT_CLK_PER_MC - 1)
`endif

// [bpt_pkg.sv]
// Types shared by the bit processor and table access block
`default_nettype none
package bpt_pkg;
	typedef enum logic [4:0] {
		BPT_OP_XRD_PTR, BPT_OP_XWR_PTR, BPT_OP_XRD_TP, BPT_OP_XWR_TP,
		BPT_OP_CRD_TP, BPT_OP_CRD_PC,
		BPT_OP_AND_BIT, BPT_OP_ANDN_BIT, BPT_OP_OR_BIT, BPT_OP_ORN_BIT,
		BPT_OP_LOAD_C, BPT_OP_STORE_C, BPT_OP_CLEAR_C, BPT_OP_CLEAR_BIT,
		BPT_OP_SET_C, BPT_OP_SET_BIT, BPT_OP_INV_C, BPT_OP_INV_BIT,
		BPT_OP_JMP_C, BPT_OP_JMP_NC, BPT_OP_JMP_B, BPT_OP_JMP_NB,
		BPT_OP_JMP_BCLR
	} bpt_op_e;
	typedef enum {BPT_ST_IDLE, BPT_ST_EXEC} bpt_state_e;
endpackage
`default_nettype wire

// [bpt_bit_decode.sv]
// Direct bit address to byte index and bit position
`timescale 1ns/1ps
`default_nettype none
`include "bpt_map.svh"
module bpt_bit_decode (
	// Direct bit address
	input  wire logic [7:0] bit_addr,
	// Decoded location
	output logic            in_sfr,
	output logic [3:0]      byte_ix,
	output logic [2:0]      bit_pos,
	output logic [7:0]      ram_byte
);
	// Upper half selects SFR space, lower half the RAM page
	assign in_sfr   = bit_addr[7];
	// Low three bits are the position, LSB first
	assign bit_pos  = bit_addr[2:0];
	// SFR byte index counts multiples of eight from the base
	assign byte_ix  = bit_addr[6:3];
	// RAM byte that holds the bit, for visibility
	assign ram_byte = `BPT_RAM_BIT_BASE + {4'h0, byte_ix};
endmodule
`default_nettype wire

// [bpt_rel_target.sv]
// Relative branch target from a signed offset byte
`timescale 1ns/1ps
`default_nettype none
module bpt_rel_target (
	// Address after the jump and offset
	input  wire logic [15:0] pc_next,
	input  wire logic [7:0]  rel,
	input  wire logic        taken,
	// Resulting program counter
	output logic [15:0]      target
);
	logic [15:0] rel_sext;
	// Sign extension keeps the reach at -128..+127
	assign rel_sext = {{8{rel[7]}}, rel};
	// Offset applies only on a taken jump
	assign target = taken ? 16'(pc_next + rel_sext) : pc_next;
endmodule
`default_nettype wire

// [bpt_core.sv]
// Bit processor, external data moves and constant reads with register bus
`timescale 1ns/1ps
`default_nettype none
`include "bpt_map.svh"
// Behaviour
// - External data uses an 8-bit bank pointer or the 16-bit table pointer
// - External data always comes from or goes to the working register
// - Read and write forms exist for both pointer widths
// - Constant reads only read program memory into the working register
// - Table form reads at table pointer plus unsigned working register
// - Counter form adds working register to the already advanced counter
// - 256 bits: low half in RAM page, high half in SFR space
// - Each port line is set, cleared or read on its own
// - Bit operands come only from the direct address in the instruction
// - Carry is the bit accumulator, also reachable by its bit address
// - Carry AND, AND NOT, OR, OR NOT with bit; no exclusive OR
// - Move bit to carry and back; clear, set, invert carry or bit
// - Jumps on carry or bit being one or zero, else fall through
// - Jump on set bit also clears that bit in the same instruction
// - Every flags word bit is bit addressable and testable
// - Signed offset is added to the counter only when taken
// - Target lies -128..+127 from the byte after the jump
// - Twelve clocks per machine cycle; external moves take two, no fetch
module bpt_core (
	// Clock and reset
	input  wire logic                core_clk,
	input  wire logic                resetn,
	// Register bus write channels
	input  wire logic                s_axi_awvalid,
	output logic                     s_axi_awready,
	input  wire logic [`BPT_AW-1:0]  s_axi_awaddr,
	input  wire logic                s_axi_wvalid,
	output logic                     s_axi_wready,
	input  wire logic [31:0]         s_axi_wdata,
	input  wire logic [3:0]          s_axi_wstrb,
	output logic                     s_axi_bvalid,
	input  wire logic                s_axi_bready,
	output logic [1:0]               s_axi_bresp,
	// Register bus read channels
	input  wire logic                s_axi_arvalid,
	output logic                     s_axi_arready,
	input  wire logic [`BPT_AW-1:0]  s_axi_araddr,
	output logic                     s_axi_rvalid,
	input  wire logic                s_axi_rready,
	output logic [31:0]              s_axi_rdata,
	output logic [1:0]               s_axi_rresp,
	// Decoded instruction
	input  wire logic                ins_valid,
	output logic                     ins_ready,
	input  wire bpt_pkg::bpt_op_e    ins_op,
	input  wire logic [7:0]          ins_bit_addr,
	input  wire logic [7:0]          ins_rel,
	input  wire logic                ins_ptr_sel,
	input  wire logic [15:0]         ins_pc_next,
	// Completion toward fetch
	output logic                     res_done,
	output logic                     res_taken,
	output logic [15:0]              res_pc_target,
	output logic                     fetch_skip,
	// External data memory
	output logic                     xd_req,
	output logic                     xd_we,
	output logic [15:0]              xd_addr,
	output logic [7:0]               xd_wdata,
	input  wire logic [7:0]          xd_rdata,
	input  wire logic                xd_ack,
	// Program memory read port
	output logic                     cm_req,
	output logic [15:0]              cm_addr,
	input  wire logic [7:0]          cm_rdata,
	input  wire logic                cm_ack,
	// Port pins
	input  wire logic [31:0]         port_pin_in,
	output logic [31:0]              port_out
);
	import bpt_pkg::*;

	// Writes one bit into a byte
	function automatic logic [7:0] put_bit(input logic [7:0] b,
		input logic [2:0] pos, input logic v);
		logic [7:0] r;
		r = b;
		r[pos] = v;
		return r;
	endfunction

	// Table base plus unsigned 0..255 index
	function automatic logic [15:0] add_idx(input logic [15:0] base,
		input logic [7:0] idx);
		return 16'(base + {8'h00, idx});
	endfunction

	// Storage: RAM bit page, bit-addressable SFRs, bank pointers
	logic [7:0]  bit_ram_ff [16];
	logic [7:0]  sfr_ff [16];
	logic [7:0]  ptr_ff [8];
	logic [15:0] tptr_ff;
	logic [31:0] pin_s1_ff;
	logic [31:0] pin_s2_ff;

	// Execution state
	bpt_state_e           st_ff;
	bpt_op_e              op_ff;
	logic [7:0]           bit_addr_ff;
	logic [7:0]           rel_ff;
	logic [15:0]          pc_next_ff;
	logic [`BPT_CNT_W-1:0] cnt_ff;
	logic                 mem_done_ff;
	logic [7:0]           mem_data_ff;
	logic                 res_done_ff;
	logic                 res_taken_ff;
	logic [15:0]          res_target_ff;
	logic                 fetch_skip_ff;
	logic                 ins_ready_ff;
	logic                 xd_req_ff;
	logic                 xd_we_ff;
	logic [15:0]          xd_addr_ff;
	logic [7:0]           xd_wdata_ff;
	logic                 cm_req_ff;
	logic [15:0]          cm_addr_ff;

	// Bus state
	logic                 awready_ff;
	logic                 wready_ff;
	logic                 aw_got_ff;
	logic                 w_got_ff;
	logic [`BPT_AW-1:0]   awaddr_ff;
	logic [31:0]          wdata_ff;
	logic [3:0]           wstrb_ff;
	logic                 bvalid_ff;
	logic [1:0]           bresp_ff;
	logic                 arready_ff;
	logic                 rvalid_ff;
	logic [31:0]          rdata_ff;
	logic [1:0]           rresp_ff;

	// Decoder outputs
	logic        dec_in_sfr;
	logic [3:0]  dec_ix;
	logic [2:0]  dec_pos;
	logic [15:0] rel_target;

	bpt_bit_decode u_dec (
		.bit_addr (bit_addr_ff),
		.in_sfr   (dec_in_sfr),
		.byte_ix  (dec_ix),
		.bit_pos  (dec_pos),
		.ram_byte ()
	);

	// Bank pointer pick and the bit and carry views
	logic [1:0]  bank;
	logic [7:0]  wreg;
	logic        carry;
	logic        is_port;
	logic [7:0]  latch_byte;
	logic [7:0]  pin_byte;
	logic        bit_test;
	logic        bit_latch;
	assign bank  = sfr_ff[`BPT_IX_FLAGS][`BPT_RS_HI:`BPT_RS_LO];
	assign wreg  = sfr_ff[`BPT_IX_WREG];
	// Carry sits in the flags word, so its bit address reaches it too
	assign carry = sfr_ff[`BPT_IX_FLAGS][`BPT_CY_POS];
	assign is_port = dec_in_sfr & (dec_ix == `BPT_IX_P0 |
		dec_ix == `BPT_IX_P1 | dec_ix == `BPT_IX_P2 |
		dec_ix == `BPT_IX_P3);
	// Operand comes only from the direct address latched at issue
	assign latch_byte = dec_in_sfr ? sfr_ff[dec_ix]
		: bit_ram_ff[dec_ix];
	assign pin_byte = pin_s2_ff[{dec_ix[2:1], 3'h0} +: 8];
	// Tests of a port line see the pin; read-modify-write uses the latch
	assign bit_test  = is_port ? pin_byte[dec_pos]
		: latch_byte[dec_pos];
	assign bit_latch = latch_byte[dec_pos];

	// Carry result, bit write-back and branch decision
	logic c_we;
	logic c_val;
	logic b_we;
	logic b_val;
	logic taken;
	logic w_load;
	always_comb
	begin
		c_we = 1'b1;
		c_val = carry;
		b_we = 1'b0;
		b_val = 1'b0;
		taken = 1'b0;
		w_load = 1'b0;
		case (op_ff)
			BPT_OP_AND_BIT:   c_val = carry & bit_test;
			BPT_OP_ANDN_BIT:  c_val = carry & ~bit_test;
			BPT_OP_OR_BIT:    c_val = carry | bit_test;
			BPT_OP_ORN_BIT:   c_val = carry | ~bit_test;
			BPT_OP_LOAD_C:    c_val = bit_test;
			BPT_OP_CLEAR_C:   c_val = 1'b0;
			BPT_OP_SET_C:     c_val = 1'b1;
			BPT_OP_INV_C:     c_val = ~carry;
			BPT_OP_STORE_C:
			begin
				c_we = 1'b0;
				b_we = 1'b1;
				b_val = carry;
			end
			BPT_OP_CLEAR_BIT, BPT_OP_SET_BIT, BPT_OP_INV_BIT:
			begin
				c_we = 1'b0;
				b_we = 1'b1;
				b_val = (op_ff == BPT_OP_SET_BIT) |
					((op_ff == BPT_OP_INV_BIT) & ~bit_latch);
			end
			BPT_OP_JMP_C:
			begin
				c_we = 1'b0;
				taken = carry;
			end
			BPT_OP_JMP_NC:
			begin
				c_we = 1'b0;
				taken = ~carry;
			end
			BPT_OP_JMP_B:
			begin
				c_we = 1'b0;
				taken = bit_test;
			end
			BPT_OP_JMP_NB:
			begin
				c_we = 1'b0;
				taken = ~bit_test;
			end
			BPT_OP_JMP_BCLR:
			begin
				c_we = 1'b0;
				taken = bit_test;
				b_we = bit_test;
			end
			BPT_OP_XRD_PTR, BPT_OP_XRD_TP, BPT_OP_CRD_TP, BPT_OP_CRD_PC:
			begin
				c_we = 1'b0;
				w_load = 1'b1;
			end
			default: c_we = 1'b0;
		endcase
	end

	bpt_rel_target u_rel (
		.pc_next (pc_next_ff),
		.rel     (rel_ff),
		.taken   (taken),
		.target  (rel_target)
	);

	// Instruction acceptance, memory request and cycle length
	logic        take;
	logic        is_ext;
	logic        is_code;
	logic        is_ptr_form;
	logic [7:0]  ptr_val;
	logic [`BPT_CNT_W-1:0] last_cnt;
	logic        finish;
	assign take   = ins_valid & (st_ff == BPT_ST_IDLE);
	assign is_ext = ins_op == BPT_OP_XRD_PTR | ins_op == BPT_OP_XWR_PTR |
		ins_op == BPT_OP_XRD_TP | ins_op == BPT_OP_XWR_TP;
	assign is_code = ins_op == BPT_OP_CRD_TP | ins_op == BPT_OP_CRD_PC;
	assign is_ptr_form = ins_op == BPT_OP_XRD_PTR |
		ins_op == BPT_OP_XWR_PTR;
	assign ptr_val = ptr_ff[{bank, ins_ptr_sel}];
	// External moves last two machine cycles, others one
	assign last_cnt = (op_ff == BPT_OP_XRD_PTR | op_ff == BPT_OP_XWR_PTR |
		op_ff == BPT_OP_XRD_TP | op_ff == BPT_OP_XWR_TP)
		? `BPT_LAST_EXT : `BPT_LAST_ONE;
	assign finish = (st_ff == BPT_ST_EXEC) & (cnt_ff >= last_cnt) &
		mem_done_ff;

	// Sequencer and memory strobes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_ff <= BPT_ST_IDLE;
			op_ff <= BPT_OP_CLEAR_C;
			bit_addr_ff <= `BPT_RESET_BYTE;
			rel_ff <= `BPT_RESET_BYTE;
			pc_next_ff <= `BPT_RESET_WORD;
			cnt_ff <= '0;
			mem_done_ff <= 1'b0;
			mem_data_ff <= `BPT_RESET_BYTE;
			xd_req_ff <= 1'b0;
			xd_we_ff <= 1'b0;
			xd_addr_ff <= `BPT_RESET_WORD;
			xd_wdata_ff <= `BPT_RESET_BYTE;
			cm_req_ff <= 1'b0;
			cm_addr_ff <= `BPT_RESET_WORD;
			fetch_skip_ff <= 1'b0;
			res_done_ff <= 1'b0;
			res_taken_ff <= 1'b0;
			res_target_ff <= `BPT_RESET_WORD;
			ins_ready_ff <= 1'b1;
		end
		else
		begin
			res_done_ff <= finish;
			if (take)
			begin
				st_ff <= BPT_ST_EXEC;
				ins_ready_ff <= 1'b0;
				op_ff <= ins_op;
				bit_addr_ff <= ins_bit_addr;
				rel_ff <= ins_rel;
				pc_next_ff <= ins_pc_next;
				cnt_ff <= '0;
				mem_done_ff <= ~(is_ext | is_code);
				xd_req_ff <= is_ext;
				xd_we_ff <= ins_op == BPT_OP_XWR_PTR | ins_op == BPT_OP_XWR_TP;
				// Short form puts the pointer on the low byte only
				xd_addr_ff <= is_ptr_form ? {8'h00, ptr_val}
					: tptr_ff;
				xd_wdata_ff <= wreg;
				cm_req_ff <= is_code;
				cm_addr_ff <= add_idx((ins_op == BPT_OP_CRD_PC) ? ins_pc_next
					: tptr_ff, wreg);
			end
			else if (st_ff == BPT_ST_EXEC)
			begin
				cnt_ff <= (cnt_ff >= last_cnt) ? cnt_ff
					: cnt_ff + 1'b1;
				if (xd_req_ff & xd_ack)
				begin
					xd_req_ff <= 1'b0;
					mem_done_ff <= 1'b1;
					mem_data_ff <= xd_rdata;
				end
				if (cm_req_ff & cm_ack)
				begin
					cm_req_ff <= 1'b0;
					mem_done_ff <= 1'b1;
					mem_data_ff <= cm_rdata;
				end
				// Second machine cycle of an external move fetches nothing
				if (cnt_ff == `BPT_LAST_ONE & last_cnt == `BPT_LAST_EXT)
					fetch_skip_ff <= 1'b1;
				if (finish)
				begin
					st_ff <= BPT_ST_IDLE;
					ins_ready_ff <= 1'b1;
					fetch_skip_ff <= 1'b0;
					res_taken_ff <= taken;
					res_target_ff <= rel_target;
				end
			end
		end
	end

	// Port pin synchroniser
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pin_s1_ff <= '0;
			pin_s2_ff <= '0;
		end
		else
		begin
			pin_s1_ff <= port_pin_in;
			pin_s2_ff <= pin_s1_ff;
		end
	end

	// Bus write decode; a write waits until address and data are both in
	logic aw_hs;
	logic w_hs;
	logic wr_fire;
	logic ar_hs;
	logic nxt_aw_got;
	logic nxt_w_got;
	logic nxt_bvalid;
	logic nxt_rvalid;
	logic wa_wreg;
	logic wa_tptr;
	logic wa_flags;
	logic wa_ptrs;
	logic wa_ro;
	assign aw_hs = s_axi_awvalid & awready_ff;
	assign w_hs = s_axi_wvalid & wready_ff;
	assign wr_fire = aw_got_ff & w_got_ff & ~bvalid_ff;
	assign ar_hs = s_axi_arvalid & arready_ff;
	assign nxt_aw_got = ~wr_fire & (aw_got_ff | aw_hs);
	assign nxt_w_got = ~wr_fire & (w_got_ff | w_hs);
	assign nxt_bvalid = wr_fire | (bvalid_ff & ~s_axi_bready);
	assign nxt_rvalid = ar_hs | (rvalid_ff & ~s_axi_rready);
	assign wa_wreg = awaddr_ff == `BPT_OFF_WREG;
	assign wa_tptr = awaddr_ff == `BPT_OFF_TPTR;
	assign wa_flags = awaddr_ff == `BPT_OFF_FLAGS;
	assign wa_ptrs = awaddr_ff == `BPT_OFF_PTRS;
	assign wa_ro = awaddr_ff == `BPT_OFF_STAT |
		awaddr_ff == `BPT_OFF_TARGET;

	// Read mux: live state of the block, zero above narrow fields
	logic [31:0] rd_word;
	logic        rd_hit;
	assign rd_hit = s_axi_araddr == `BPT_OFF_WREG |
		s_axi_araddr == `BPT_OFF_TPTR | s_axi_araddr == `BPT_OFF_FLAGS |
		s_axi_araddr == `BPT_OFF_PTRS | s_axi_araddr == `BPT_OFF_STAT |
		s_axi_araddr == `BPT_OFF_TARGET;
	assign rd_word =
		(s_axi_araddr == `BPT_OFF_WREG)   ? {24'h00_0000, wreg} :
		(s_axi_araddr == `BPT_OFF_TPTR)   ? {16'h0000, tptr_ff} :
		(s_axi_araddr == `BPT_OFF_FLAGS)  ?
			{24'h00_0000, sfr_ff[`BPT_IX_FLAGS]} :
		(s_axi_araddr == `BPT_OFF_PTRS)   ?
			{16'h0000, ptr_ff[{bank, 1'b1}], ptr_ff[{bank, 1'b0}]} :
		(s_axi_araddr == `BPT_OFF_STAT)   ? {28'h000_0000,
			fetch_skip_ff, res_taken_ff, mem_done_ff,
			st_ff == BPT_ST_EXEC} :
		(s_axi_araddr == `BPT_OFF_TARGET) ? {16'h0000, res_target_ff} :
		32'h0000_0000;

	// Bus channel handshakes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			awready_ff <= 1'b0;
			wready_ff <= 1'b0;
			aw_got_ff <= 1'b0;
			w_got_ff <= 1'b0;
			awaddr_ff <= '0;
			wdata_ff <= 32'h0000_0000;
			wstrb_ff <= 4'h0;
			bvalid_ff <= 1'b0;
			bresp_ff <= `BPT_RESP_OK;
			arready_ff <= 1'b0;
			rvalid_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
			rresp_ff <= `BPT_RESP_OK;
		end
		else
		begin
			aw_got_ff <= nxt_aw_got;
			w_got_ff <= nxt_w_got;
			awready_ff <= ~nxt_aw_got & ~nxt_bvalid;
			wready_ff <= ~nxt_w_got & ~nxt_bvalid;
			bvalid_ff <= nxt_bvalid;
			rvalid_ff <= nxt_rvalid;
			arready_ff <= ~nxt_rvalid;
			if (aw_hs)
				awaddr_ff <= s_axi_awaddr;
			if (w_hs)
			begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
			if (wr_fire)
				bresp_ff <= (wa_wreg | wa_tptr | wa_flags | wa_ptrs | wa_ro)
					? `BPT_RESP_OK : `BPT_RESP_ERR;
			if (ar_hs)
			begin
				rdata_ff <= rd_word;
				rresp_ff <= rd_hit ? `BPT_RESP_OK : `BPT_RESP_ERR;
			end
		end
	end

	// Architectural storage; the finishing instruction wins over software
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			for (int i = 0; i < 16; i++)
			begin
				bit_ram_ff[i] <= `BPT_RESET_BYTE;
				sfr_ff[i] <= `BPT_RESET_BYTE;
			end
			for (int j = 0; j < 8; j++)
				ptr_ff[j] <= `BPT_RESET_BYTE;
			tptr_ff <= `BPT_RESET_WORD;
		end
		else
		begin
			if (wr_fire & wa_wreg & wstrb_ff[0])
				sfr_ff[`BPT_IX_WREG] <= wdata_ff[7:0];
			if (wr_fire & wa_flags & wstrb_ff[0])
				sfr_ff[`BPT_IX_FLAGS] <= wdata_ff[7:0];
			if (wr_fire & wa_tptr & wstrb_ff[0])
				tptr_ff[7:0] <= wdata_ff[7:0];
			if (wr_fire & wa_tptr & wstrb_ff[1])
				tptr_ff[15:8] <= wdata_ff[15:8];
			if (wr_fire & wa_ptrs & wstrb_ff[0])
				ptr_ff[{bank, 1'b0}] <= wdata_ff[7:0];
			if (wr_fire & wa_ptrs & wstrb_ff[1])
				ptr_ff[{bank, 1'b1}] <= wdata_ff[15:8];
			if (finish & w_load)
				sfr_ff[`BPT_IX_WREG] <= mem_data_ff;
			if (finish & c_we)
				sfr_ff[`BPT_IX_FLAGS] <= put_bit(sfr_ff[`BPT_IX_FLAGS],
					`BPT_CY_POS, c_val);
			// Single-bit write leaves the neighbours of the line alone
			if (finish & b_we & dec_in_sfr)
				sfr_ff[dec_ix] <= put_bit(latch_byte, dec_pos, b_val);
			if (finish & b_we & ~dec_in_sfr)
				bit_ram_ff[dec_ix] <= put_bit(latch_byte, dec_pos,
					b_val);
		end
	end

	// Outputs straight from flops
	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;
	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
	assign res_done      = res_done_ff;
	assign res_taken     = res_taken_ff;
	assign res_pc_target = res_target_ff;
	assign fetch_skip    = fetch_skip_ff;
	assign xd_req        = xd_req_ff;
	assign xd_we         = xd_we_ff;
	assign xd_addr       = xd_addr_ff;
	assign xd_wdata      = xd_wdata_ff;
	assign cm_req        = cm_req_ff;
	assign cm_addr       = cm_addr_ff;
	assign ins_ready     = ins_ready_ff;
	assign port_out = {sfr_ff[`BPT_IX_P3], sfr_ff[`BPT_IX_P2],
		sfr_ff[`BPT_IX_P1], sfr_ff[`BPT_IX_P0]};
endmodule
`default_nettype wire

// [bpt_assertions.sv]
// Port timing checks for the bit processor block
`timescale 1ns/1ps
`default_nettype none
module bpt_assertions (
	// Clock, reset, instruction side
	input wire logic             core_clk,
	input wire logic             resetn,
	input wire logic             ins_valid,
	input wire logic             ins_ready,
	input wire bpt_pkg::bpt_op_e ins_op,
	input wire logic             res_done,
	input wire logic             fetch_skip,
	// Memory side
	input wire logic             xd_req,
	input wire logic             xd_ack,
	input wire logic             xd_we,
	input wire logic [15:0]      xd_addr,
	input wire logic             cm_req,
	input wire logic             cm_ack
);
	import bpt_pkg::*;
	// Accepted instruction and its class
	wire tk = ins_valid && ins_ready;
	wire pf = ins_op inside {BPT_OP_XRD_PTR, BPT_OP_XWR_PTR};
	wire wf = ins_op inside {BPT_OP_XWR_PTR, BPT_OP_XWR_TP};
	wire xm = pf || ins_op inside {BPT_OP_XRD_TP, BPT_OP_XWR_TP};
	wire cr = ins_op inside {BPT_OP_CRD_TP, BPT_OP_CRD_PC};
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	a_xd_held: assert property (xd_req && !xd_ack |=> xd_req
		&& $stable(xd_addr) && $stable(xd_we)) else $error("xd moved");
	a_ptr_high: assert property (tk && pf |=> xd_addr[15:8] == 8'h00)
		else $error("ptr high");
	a_xd_dir: assert property (tk && xm |=> xd_req && xd_we == $past(wf))
		else $error("xd dir");
	a_crd_code: assert property (tk && cr |=> cm_req && !xd_req)
		else $error("crd path");
	a_cm_held: assert property (cm_req && !cm_ack |=> cm_req)
		else $error("cm drop");
	a_one_mc: assert property (tk && !xm && !cr
		|=> !res_done [*8] ##[4:6] res_done) else $error("one mc");
	a_two_mc: assert property (tk && xm
		|=> !res_done [*8] ##1 !res_done [*8] ##[8:60] res_done)
		else $error("two mc");
	a_skip_ext: assert property (tk && xm |-> ##[12:14] fetch_skip)
		else $error("no skip");
endmodule
bind bpt_core bpt_assertions chk_u (.core_clk, .resetn, .ins_valid,
	.ins_ready, .ins_op, .res_done, .fetch_skip, .xd_req, .xd_ack,
	.xd_we, .xd_addr, .cm_req, .cm_ack);
`default_nettype wire

// [bpt_mem_model.sv]
// Behavioural external data and program memories
`timescale 1ns/1ps
`default_nettype none
module bpt_mem_model (
	// Clock and wait states
	input wire logic        core_clk,
	input wire logic [1:0]  lat,
	// External data memory
	input wire logic        xd_req,
	input wire logic        xd_we,
	input wire logic [15:0] xd_addr,
	input wire logic [7:0]  xd_wdata,
	output logic [7:0]      xd_rdata = 8'h00,
	output logic            xd_ack = 1'b0,
	// Program memory, byte fixed by address
	input wire logic        cm_req,
	input wire logic [15:0] cm_addr,
	output logic [7:0]      cm_rdata = 8'h00,
	output logic            cm_ack = 1'b0
);
	logic [7:0] mem [0:65535];
	logic [1:0] xw = 2'h0;
	logic [1:0] cw = 2'h0;
	// Answer after lat waits; data toggles outside the ack cycle
	always @(posedge core_clk)
	begin
		xd_ack <= 1'b0;
		cm_ack <= 1'b0;
		xd_rdata <= ~xd_rdata;
		cm_rdata <= ~cm_rdata;
		xw <= (xd_req && !xd_ack && xw != lat) ? xw + 2'h1 : 2'h0;
		cw <= (cm_req && !cm_ack && cw != lat) ? cw + 2'h1 : 2'h0;
		if (xd_req && !xd_ack && xw == lat)
		begin
			xd_ack <= 1'b1;
			xd_rdata <= mem[xd_addr];
			if (xd_we)
				mem[xd_addr] <= xd_wdata;
		end
		if (cm_req && !cm_ack && cw == lat)
		begin
			cm_ack <= 1'b1;
			cm_rdata <= cm_addr[7:0] ^ cm_addr[15:8];
		end
	end
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the bit processor block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bpt_pkg::*;
	logic core_clk = 1'b0, resetn = 1'b0, s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0, ins_valid = 1'b0, ins_ptr_sel = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [7:0] ins_bit_addr = 8'h00, ins_rel = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [15:0] ins_pc_next = 16'h0000;
	logic [1:0] lat = 2'h0;
	bpt_op_e ins_op = BPT_OP_SET_C;
	// Design and model outputs
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, ins_ready, res_done, res_taken, fetch_skip;
	logic xd_req, xd_we, xd_ack, cm_req, cm_ack;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
	logic [7:0] xd_wdata, xd_rdata, cm_rdata;
	logic [15:0] res_pc_target, xd_addr, cm_addr;
	logic [31:0] s_axi_rdata, port_out, rd_d;
	int err_count = 0, n_tests = 0, cyc = 0;
	bpt_core dut_u (.*, .s_axi_wstrb(4'hF), .port_pin_in(32'h0020_0000));
	bpt_mem_model mem_u (.*);
	// 40 MHz clock
	always #12.5 core_clk = ~core_clk;
	task automatic conclude;
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(logic [31:0] g, logic [31:0] e);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("mismatch at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Bus tasks start right after an edge and leave one edge spare
	task automatic wr(logic [7:0] a, logic [31:0] d);
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		do
		begin
			@(posedge core_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(logic [7:0] a);
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		s_axi_araddr <= a;
		do
		begin
			@(posedge core_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd_d = s_axi_rdata;
		rd_r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge core_clk);
	endtask
	// One instruction; bit 0 of the bit address also picks the pointer
	task automatic ex(bpt_op_e op, logic [7:0] b, logic [7:0] r = 8'h00);
		ins_valid <= 1'b1;
		ins_op <= op;
		ins_bit_addr <= b;
		ins_rel <= r;
		ins_ptr_sel <= b[0];
		ins_pc_next <= 16'h0100;
		do @(posedge core_clk); while (ins_ready !== 1'b1);
		ins_valid <= 1'b0;
		do @(posedge core_clk); while (res_done !== 1'b1);
	endtask
	task automatic jt(bpt_op_e op, logic [7:0] b, r, logic t, logic [15:0] p);
		ex(op, b, r);
		chk({res_taken, res_pc_target}, {t, p});
	endtask
	// Both pointer widths, read and write, slow memory on one read
	task automatic t_ext;
		wr(8'h0C, 32'h0000_4231);
		wr(8'h00, 32'h0000_00A5);
		ex(BPT_OP_XWR_PTR, 8'h01);
		wr(8'h04, 32'h0000_0042);
		wr(8'h00, 32'h0000_005A);
		lat <= 2'h3;
		ex(BPT_OP_XRD_TP, 8'h00);
		lat <= 2'h0;
		rd(8'h00);
		chk(rd_d, 32'h0000_00A5);
		wr(8'h04, 32'h0000_0031);
		ex(BPT_OP_XWR_TP, 8'h00);
		wr(8'h00, 32'h0000_0000);
		ex(BPT_OP_XRD_PTR, 8'h00);
		rd(8'h00);
		chk(rd_d, 32'h0000_00A5);
	endtask
	// Both constant read bases, full unsigned index
	task automatic t_crd;
		wr(8'h04, 32'h0000_10F0);
		wr(8'h00, 32'h0000_00FF);
		ex(BPT_OP_CRD_TP, 8'h00);
		rd(8'h00);
		chk(rd_d, 32'h0000_00FE);
		wr(8'h00, 32'h0000_0005);
		ex(BPT_OP_CRD_PC, 8'h00);
		rd(8'h00);
		chk(rd_d, 32'h0000_0004);
	endtask
	// Carry logic table, carry by address, port bits
	task automatic t_bits;
		bpt_op_e ops [4] = '{BPT_OP_AND_BIT, BPT_OP_ANDN_BIT,
			BPT_OP_OR_BIT, BPT_OP_ORN_BIT};
		logic [3:0] c0 = 4'b0011;
		logic [3:0] cx = 4'b0101;
		ex(BPT_OP_SET_BIT, 8'h0B);
		for (int i = 0; i < 4; i++)
		begin
			ex(c0[i] ? BPT_OP_SET_C : BPT_OP_CLEAR_C, 8'h00);
			ex(ops[i], 8'h0B);
			rd(8'h08);
			chk(rd_d, {24'h0, cx[i], 7'h0});
		end
		ex(BPT_OP_LOAD_C, 8'hA5);
		ex(BPT_OP_STORE_C, 8'h91);
		chk(port_out, 32'h0000_0200);
		ex(BPT_OP_INV_BIT, 8'h91);
		chk(port_out, 32'h0000_0000);
		ex(BPT_OP_CLEAR_BIT, 8'hD7);
		rd(8'h08);
		chk(rd_d, 32'h0000_0000);
		rd(8'h40);
		chk({30'h0, rd_r}, 32'h0000_0002);
	endtask
	// Jumps: taken, not taken, both offset limits
	task automatic t_jmp;
		jt(BPT_OP_JMP_B, 8'h0B, 8'h80, 1'b1, 16'h0080);
		jt(BPT_OP_JMP_NB, 8'h0B, 8'h80, 1'b0, 16'h0100);
		jt(BPT_OP_JMP_BCLR, 8'h0B, 8'h7F, 1'b1, 16'h017F);
		jt(BPT_OP_JMP_BCLR, 8'h0B, 8'h7F, 1'b0, 16'h0100);
		jt(BPT_OP_JMP_NB, 8'h0B, 8'hFE, 1'b1, 16'h00FE);
		jt(BPT_OP_JMP_NC, 8'h00, 8'h10, 1'b1, 16'h0110);
		ex(BPT_OP_INV_C, 8'h00);
		jt(BPT_OP_JMP_C, 8'h00, 8'h10, 1'b1, 16'h0110);
		jt(BPT_OP_JMP_B, 8'hA4, 8'h01, 1'b0, 16'h0100);
		ex(BPT_OP_SET_BIT, 8'hD2);
		jt(BPT_OP_JMP_B, 8'hD2, 8'h02, 1'b1, 16'h0102);
	endtask
	// Hang guard
	always @(posedge core_clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 8000)
		begin
			err_count++;
			conclude();
		end
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (2) @(posedge core_clk);
		t_ext();
		t_crd();
		t_bits();
		t_jmp();
		conclude();
	end
endmodule
`default_nettype wire
